/* File: common/pcs_consts.vh */
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH

// APB address and data
`define PCS_ADDR_W 18
`define PCS_DATA_W 32
`define PCS_REG_W 16

// Register indices; the byte address is four times the index
`define PCS_IDX_PHA 16'he614
`define PCS_IDX_PHB 16'he615
`define PCS_IDX_PHC 16'he616
`define PCS_IDX_SIGN 16'he617
`define PCS_IDX_ACCUMULATION_MODE_REG 16'he620
`define PCS_IDX_COMPUTATION_MODE_REG 16'he621
`define PCS_IDX_PULSEMODE 16'he622
`define PCS_IDX_IRQSTAT 16'he623
`define PCS_IDX_IRQMASK 16'he624

// Reset values
`define PCS_RST_PHCOMP 10'h000
`define PCS_RST_SIGN 9'h000
`define PCS_RST_ACCUMULATION_MODE_REG 1'h0
`define PCS_RST_COMPUTATION_MODE_REG 9'h1ff
`define PCS_RST_PULSEMODE 9'h088
`define PCS_RST_IRQ 9'h000

// Field layouts
`define PCS_COMP_W 10
`define PCS_SIGN_W 9
`define PCS_SEL_W 9
`define PCS_ACC_REVAP 6
`define PCS_ACC_REVRP 7
`define PCS_SIGN_ACT_LSB 0
`define PCS_SIGN_SUM1 3
`define PCS_SIGN_REACT_LSB 4
`define PCS_SIGN_SUM2 7
`define PCS_SIGN_SUM3 8

// Quantity select codes
`define PCS_Q_TOT_ACT 3'h0
`define PCS_Q_TOT_REACT 3'h1
`define PCS_Q_APPARENT 3'h2
`define PCS_Q_FUND_ACT 3'h3
`define PCS_Q_FUND_REACT 3'h4

// Phase compensation ranges
`define PCS_PH_LO_ALIAS_MIN 10'h180
`define PCS_PH_LO_ALIAS_MAX 10'h1ff
`define PCS_PH_HI_ALIAS_MIN 10'h240
`define PCS_PH_HI_ALIAS_BASE 10'h180
`define PCS_PH_ALIAS_SHIFT 10'h080
`define PCS_PH_ALIAS_W 7

`endif

/* File: rtl/pcs_regs.v */
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "pcs_consts.vh"

module pcs_regs #(
    parameter PWR_W = 24,
    parameter HAS_REACTIVE = 1
) (
    input wire core_clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PCS_ADDR_W-1:0] paddr,
    input wire [`PCS_DATA_W-1:0] pwdata,
    output reg [`PCS_DATA_W-1:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [3*PWR_W-1:0] totActPwr,
    input wire [3*PWR_W-1:0] totReactPwr,
    input wire [3*PWR_W-1:0] apparentPwr,
    input wire [3*PWR_W-1:0] fundActPwr,
    input wire [3*PWR_W-1:0] fundReactPwr,
    output reg [`PCS_COMP_W-1:0] phaseACompEff,
    output reg [`PCS_COMP_W-1:0] phaseBCompEff,
    output reg [`PCS_COMP_W-1:0] phaseCCompEff,
    output reg [`PCS_SIGN_W-1:0] signOut,
    output reg irq
);

    localparam SUM_W = PWR_W + 2;

    reg [`PCS_COMP_W-1:0] phaseAComp_ff;
    reg [`PCS_COMP_W-1:0] phaseBComp_ff;
    reg [`PCS_COMP_W-1:0] phaseCComp_ff;
    reg [`PCS_SIGN_W-1:0] powerSign_ff;
    reg activeRevSel_ff;
    reg reactiveRevSel_ff;
    reg [`PCS_SEL_W-1:0] phaseTerms_ff;
    reg [`PCS_SEL_W-1:0] pulseQuantity_ff;
    reg [`PCS_SIGN_W-1:0] irqStat_ff;
    reg [`PCS_SIGN_W-1:0] irqMask_ff;

    reg [`PCS_SIGN_W-1:0] nxt_powerSign;
    reg [`PCS_SIGN_W-1:0] nxt_irqStat;
    reg [`PCS_DATA_W-1:0] rdMux;
    reg addrHit;
    wire [2:0] pathNeg;

    wire apbAccess;
    wire apbDone;
    wire wrEn;
    wire [15:0] regIdx;
    wire alignOk;
    wire accessFirst;
    wire [`PCS_SIGN_W-1:0] signEvent;
    wire irqClr;

    // Maps a programmed phase value onto the value that compensates
    function [`PCS_COMP_W-1:0] compAlias;
        input [`PCS_COMP_W-1:0] val;
        reg [`PCS_COMP_W-1:0] stage;
        reg [`PCS_COMP_W-1:0] offset;
        begin
            stage = val;
            offset = val - `PCS_PH_HI_ALIAS_MIN;
            // Upper lag band folds modulo 128 onto 384..511
            if (stage >= `PCS_PH_HI_ALIAS_MIN) begin
                stage = `PCS_PH_HI_ALIAS_BASE
                    + {{(`PCS_COMP_W-`PCS_PH_ALIAS_W){1'b0}},
                    offset[`PCS_PH_ALIAS_W-1:0]};
            end
            // 384..511 compensates as the value 128 lower
            if ((stage >= `PCS_PH_LO_ALIAS_MIN) &&
                (stage <= `PCS_PH_LO_ALIAS_MAX)) begin
                stage = stage - `PCS_PH_ALIAS_SHIFT;
            end
            compAlias = stage;
        end
    endfunction

    // Pulse path sums and their signs
    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1) begin : gPath
            wire [2:0] terms;
            wire [2:0] qsel;
            reg [3*PWR_W-1:0] selBus;
            reg qValid;
            reg signed [SUM_W-1:0] sum;
            integer k;

            assign terms = phaseTerms_ff[3*p+2:3*p];
            assign qsel = pulseQuantity_ff[3*p+2:3*p];

            always @* begin
                qValid = 1'b1;
                case (qsel)
                    `PCS_Q_TOT_ACT: begin
                        selBus = totActPwr;
                    end
                    `PCS_Q_TOT_REACT: begin
                        selBus = totReactPwr;
                    end
                    `PCS_Q_APPARENT: begin
                        selBus = apparentPwr;
                    end
                    `PCS_Q_FUND_ACT: begin
                        selBus = fundActPwr;
                    end
                    `PCS_Q_FUND_REACT: begin
                        selBus = fundReactPwr;
                    end
                    default: begin
                        selBus = {3*PWR_W{1'b0}};
                        qValid = 1'b0;
                    end
                endcase
            end

            // Two guard bits keep a three-phase sum from overflowing
            always @* begin
                sum = {SUM_W{1'b0}};
                for (k = 0; k < 3; k = k + 1) begin
                    if (terms[k]) begin
                        sum = sum + {{2{selBus[k*PWR_W+PWR_W-1]}},
                                     selBus[k*PWR_W +: PWR_W]};
                    end
                end
            end

            assign pathNeg[p] = qValid & sum[SUM_W-1];
        end
    endgenerate

    // Next value of the sign status
    integer ph;
    always @* begin
        nxt_powerSign = `PCS_RST_SIGN;
        for (ph = 0; ph < 3; ph = ph + 1) begin
            if (activeRevSel_ff) begin
                nxt_powerSign[`PCS_SIGN_ACT_LSB + ph] =
                    fundActPwr[ph*PWR_W+PWR_W-1];
            end else begin
                nxt_powerSign[`PCS_SIGN_ACT_LSB + ph] =
                    totActPwr[ph*PWR_W+PWR_W-1];
            end
            if (HAS_REACTIVE != 0) begin
                if (reactiveRevSel_ff) begin
                    nxt_powerSign[`PCS_SIGN_REACT_LSB + ph] =
                        fundReactPwr[ph*PWR_W+PWR_W-1];
                end else begin
                    nxt_powerSign[`PCS_SIGN_REACT_LSB + ph] =
                        totReactPwr[ph*PWR_W+PWR_W-1];
                end
            end else begin
                nxt_powerSign[`PCS_SIGN_REACT_LSB + ph] = 1'b0;
            end
        end
        // Pulse path sums give bits 3, 7 and 8
        nxt_powerSign[`PCS_SIGN_SUM1] = pathNeg[0];
        nxt_powerSign[`PCS_SIGN_SUM2] = pathNeg[1];
        nxt_powerSign[`PCS_SIGN_SUM3] = pathNeg[2];
    end

    // Sign status tracks the datapath on every clock
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            powerSign_ff <= `PCS_RST_SIGN;
        end else begin
            powerSign_ff <= nxt_powerSign;
        end
    end

    // APB decode
    assign apbAccess = psel & penable;
    // A write lands at the edge that samples ready high
    assign apbDone = apbAccess & pready;
    assign wrEn = apbDone & pwrite & addrHit;
    assign regIdx = paddr[`PCS_ADDR_W-1:2];
    assign alignOk = (paddr[1:0] == 2'h0);
    assign accessFirst = apbAccess & ~pready;

    always @* begin
        addrHit = alignOk;
        rdMux = {`PCS_DATA_W{1'b0}};
        case (regIdx)
            `PCS_IDX_PHA: begin
                rdMux[`PCS_COMP_W-1:0] = phaseAComp_ff;
            end
            `PCS_IDX_PHB: begin
                rdMux[`PCS_COMP_W-1:0] = phaseBComp_ff;
            end
            `PCS_IDX_PHC: begin
                rdMux[`PCS_COMP_W-1:0] = phaseCComp_ff;
            end
            `PCS_IDX_SIGN: begin
                rdMux[`PCS_SIGN_W-1:0] = powerSign_ff;
            end
            `PCS_IDX_ACCUMULATION_MODE_REG: begin
                rdMux[`PCS_ACC_REVAP] = activeRevSel_ff;
                rdMux[`PCS_ACC_REVRP] = reactiveRevSel_ff;
            end
            `PCS_IDX_COMPUTATION_MODE_REG: begin
                rdMux[`PCS_SEL_W-1:0] = phaseTerms_ff;
            end
            `PCS_IDX_PULSEMODE: begin
                rdMux[`PCS_SEL_W-1:0] = pulseQuantity_ff;
            end
            `PCS_IDX_IRQSTAT: begin
                rdMux[`PCS_SIGN_W-1:0] = irqStat_ff;
            end
            `PCS_IDX_IRQMASK: begin
                rdMux[`PCS_SIGN_W-1:0] = irqMask_ff;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    // One wait state, then the answer with data and error
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= {`PCS_DATA_W{1'b0}};
            pslverr <= 1'b0;
        end else begin
            // Ready lasts one cycle; a held access is answered again every second cycle
            pready <= accessFirst;
            if (accessFirst) begin
                prdata <= pwrite ? {`PCS_DATA_W{1'b0}} : rdMux;
                // Unmapped reads zero, unaligned reads the register; both report an error
                pslverr <= ~addrHit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // Writable registers; the sign status takes no write
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phaseAComp_ff <= `PCS_RST_PHCOMP;
            phaseBComp_ff <= `PCS_RST_PHCOMP;
            phaseCComp_ff <= `PCS_RST_PHCOMP;
            activeRevSel_ff <= `PCS_RST_ACCUMULATION_MODE_REG;
            reactiveRevSel_ff <= `PCS_RST_ACCUMULATION_MODE_REG;
            phaseTerms_ff <= `PCS_RST_COMPUTATION_MODE_REG;
            pulseQuantity_ff <= `PCS_RST_PULSEMODE;
            irqMask_ff <= `PCS_RST_IRQ;
        end else if (wrEn) begin
            // Reserved upper bits are not stored
            case (regIdx)
                `PCS_IDX_PHA: begin
                    phaseAComp_ff <= pwdata[`PCS_COMP_W-1:0];
                end
                `PCS_IDX_PHB: begin
                    phaseBComp_ff <= pwdata[`PCS_COMP_W-1:0];
                end
                `PCS_IDX_PHC: begin
                    phaseCComp_ff <= pwdata[`PCS_COMP_W-1:0];
                end
                `PCS_IDX_ACCUMULATION_MODE_REG: begin
                    activeRevSel_ff <= pwdata[`PCS_ACC_REVAP];
                    reactiveRevSel_ff <= pwdata[`PCS_ACC_REVRP];
                end
                `PCS_IDX_COMPUTATION_MODE_REG: begin
                    phaseTerms_ff <= pwdata[`PCS_SEL_W-1:0];
                end
                `PCS_IDX_PULSEMODE: begin
                    pulseQuantity_ff <= pwdata[`PCS_SEL_W-1:0];
                end
                `PCS_IDX_IRQMASK: begin
                    irqMask_ff <= pwdata[`PCS_SIGN_W-1:0];
                end
                default: begin
                    irqMask_ff <= irqMask_ff;
                end
            endcase
        end
    end

    // Any toggle of a sign bit is an event
    assign signEvent = nxt_powerSign ^ powerSign_ff;
    assign irqClr = wrEn & (regIdx == `PCS_IDX_IRQSTAT);

    // Events latch; a new event beats a clear in the same cycle
    always @* begin
        nxt_irqStat = irqStat_ff;
        if (irqClr) begin
            nxt_irqStat = irqStat_ff & ~pwdata[`PCS_SIGN_W-1:0];
        end
        nxt_irqStat = nxt_irqStat | signEvent;
    end

    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irqStat_ff <= `PCS_RST_IRQ;
            irq <= 1'b0;
        end else begin
            irqStat_ff <= nxt_irqStat;
            // Built from the next status so a fresh event is not late
            irq <= |(nxt_irqStat & irqMask_ff);
        end
    end

    // Registered outputs
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phaseACompEff <= `PCS_RST_PHCOMP;
            phaseBCompEff <= `PCS_RST_PHCOMP;
            phaseCCompEff <= `PCS_RST_PHCOMP;
            signOut <= `PCS_RST_SIGN;
        end else begin
            phaseACompEff <= compAlias(phaseAComp_ff);
            phaseBCompEff <= compAlias(phaseBComp_ff);
            phaseCCompEff <= compAlias(phaseCComp_ff);
            // Same value the sign register takes at this edge
            signOut <= nxt_powerSign;
        end
    end

endmodule // pcs_regs

/* File: sim/pcs_regs_assertions.sv */
`timescale 1ns/10ps
`include "pcs_consts.vh"
module pcs_regs_checker #(
    parameter PWR_W = 24,
    parameter HAS_REACTIVE = 1
) (
    input wire core_clk,
    input wire sys_rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`PCS_ADDR_W-1:0] paddr,
    input wire [`PCS_DATA_W-1:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [3*PWR_W-1:0] totActPwr,
    input wire [3*PWR_W-1:0] totReactPwr,
    input wire [3*PWR_W-1:0] fundActPwr,
    input wire [3*PWR_W-1:0] fundReactPwr,
    input wire [`PCS_COMP_W-1:0] phaseACompEff,
    input wire [`PCS_COMP_W-1:0] phaseBCompEff,
    input wire [`PCS_COMP_W-1:0] phaseCCompEff,
    input wire [`PCS_SIGN_W-1:0] signOut
);
    function automatic [2:0] sg(input [3*PWR_W-1:0] p);
        sg = {p[3*PWR_W-1], p[2*PWR_W-1], p[PWR_W-1]};
    endfunction
    function automatic ok(input [9:0] v);
        ok = v < 10'h180 || (v >= 10'h200 && v <= 10'h23f);
    endfunction
    wire [2:0] ta = sg(totActPwr);
    wire [2:0] fa = sg(fundActPwr);
    wire [2:0] tr = sg(totReactPwr);
    wire [2:0] fr = sg(fundReactPwr);
    wire [15:0] idx = paddr[17:2];
    wire rdSign = pready && !pwrite && idx == `PCS_IDX_SIGN;
    wire wrSign = pready && pwrite && idx == `PCS_IDX_SIGN;
    wire rdPh = pready && !pwrite && idx >= `PCS_IDX_PHA
        && idx <= `PCS_IDX_PHC;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    ready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after access");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held too long");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    sign_upper_a: assert property (
        rdSign |-> prdata[31:9] == 23'h0 && !pslverr)
        else $error("sign read upper bits set");
    comp_upper_a: assert property (rdPh |-> prdata[31:10] == 22'h0)
        else $error("phase read upper bits set");
    eff_range_a: assert property (
        ok(phaseACompEff) && ok(phaseBCompEff) && ok(phaseCCompEff))
        else $error("effective phase value not aliased");
    act_sign_a: assert property (
        ta == fa |=> signOut[2:0] == $past(ta))
        else $error("active sign wrong");
    react_sign_a: assert property (
        tr == fr |=> signOut[6:4] == (HAS_REACTIVE != 0 ? $past(tr) : 3'h0))
        else $error("reactive sign wrong");
    sign_write_a: assert property (wrSign |-> !pslverr)
        else $error("sign write refused");
endmodule // pcs_regs_checker

/* File: sim/phase_cal_and_power_sign_regs_bench.sv */
`timescale 1ns/10ps
`include "pcs_consts.vh"
module phase_cal_and_power_sign_regs_bench;
    localparam [59:0] VALS = {10'h3ff, 10'h240, 10'h23f, 10'h1ff,
        10'h180, 10'h17f};
    reg core_clk = 1'b0;
    reg sys_rst = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [17:0] paddr = 18'h0;
    reg [31:0] pwdata = 32'h0;
    reg [71:0] tA = 72'h0, tR = 72'h0, ap = 72'h0, fA = 72'h0, fR = 72'h0;
    wire [31:0] prdata;
    wire pready, pslverr, irq;
    wire [9:0] effA, effB, effC;
    wire [8:0] signOut;
    reg [31:0] rdVal;
    reg errVal;
    reg [9:0] v;
    reg [1:0] k;
    integer err_total = 0, n_compared = 0, i;
    wire [8:0] nrSign;
    always #5 core_clk = ~core_clk;
    pcs_regs dut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .totActPwr(tA), .totReactPwr(tR), .apparentPwr(ap),
        .fundActPwr(fA), .fundReactPwr(fR), .phaseACompEff(effA),
        .phaseBCompEff(effB), .phaseCCompEff(effC), .signOut(signOut),
        .irq(irq));
    pcs_regs #(.HAS_REACTIVE(0)) dutNoReact (.core_clk(core_clk),
        .sys_rst(sys_rst), .psel(1'b0), .penable(1'b0), .pwrite(1'b0),
        .paddr(18'h0), .pwdata(32'h0), .prdata(), .pready(), .pslverr(),
        .totActPwr(tA), .totReactPwr(tR), .apparentPwr(ap),
        .fundActPwr(fA), .fundReactPwr(fR), .phaseACompEff(),
        .phaseBCompEff(), .phaseCCompEff(), .signOut(nrSign), .irq());
    function [71:0] ph(input [23:0] a, input [23:0] b, input [23:0] c);
        ph = {c, b, a};
    endfunction
    function [9:0] effOf(input [9:0] x);
        effOf = x < 10'h180 ? x : x < 10'h200 ? x - 10'h080 :
            x < 10'h240 ? x : 10'h100 + ((x - 10'h240) & 10'h07f);
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task xfer(input [15:0] x, input w, input [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {x, 2'b00};
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdVal = prdata;
        errVal = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input [15:0] x, input [31:0] d);
        xfer(x, 1'b1, d);
        chk({31'h0, errVal}, 32'h0);
        repeat (3) @(posedge core_clk);
    endtask
    task rc(input [15:0] x, input [31:0] e, input er);
        xfer(x, 1'b0, 32'h0);
        chk(rdVal, e);
        chk({31'h0, errVal}, {31'h0, er});
    endtask
    task tally_and_finish;
        $display("compared %0d, wrong %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #200000;
        err_total = err_total + 1;
        tally_and_finish;
    end
    initial begin
        repeat (16) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 4; i = i + 1)
            rc(16'he614 + i[15:0], 32'h0, 1'b0);
        rc(`PCS_IDX_COMPUTATION_MODE_REG, 32'h1ff, 1'b0);
        rc(`PCS_IDX_PULSEMODE, 32'h088, 1'b0);
        rc(16'he618, 32'h0, 1'b1);
        for (i = 0; i < 6; i = i + 1) begin
            v = VALS[i*10 +: 10];
            k = i % 3;
            wr(16'he614 + {14'h0, k}, {22'h3fffff, v});
            rc(16'he614 + {14'h0, k}, {22'h0, v}, 1'b0);
            chk({22'h0, k == 0 ? effA : k == 1 ? effB : effC},
                {22'h0, effOf(v)});
        end
        rc(`PCS_IDX_PHA, 32'h23f, 1'b0);
        @(posedge core_clk);
        tA <= ph(-24'h64, 24'h32, -24'h0a);
        tR <= ph(24'h5, -24'h14, 24'h5);
        ap <= ph(-24'h12c, 24'h64, 24'h64);
        fA <= ph(24'h64, -24'h32, 24'h0a);
        fR <= ph(-24'h5, 24'h14, 24'h32);
        repeat (3) @(posedge core_clk);
        rc(`PCS_IDX_SIGN, 32'h1ad, 1'b0);
        chk({29'h0, nrSign[6:4]}, 32'h0);
        wr(`PCS_IDX_SIGN, 32'h0);
        rc(`PCS_IDX_SIGN, 32'h1ad, 1'b0);
        wr(`PCS_IDX_ACCUMULATION_MODE_REG, 32'h40);
        rc(`PCS_IDX_SIGN, 32'h1aa, 1'b0);
        wr(`PCS_IDX_ACCUMULATION_MODE_REG, 32'h80);
        rc(`PCS_IDX_SIGN, 32'h19d, 1'b0);
        wr(`PCS_IDX_ACCUMULATION_MODE_REG, 32'h0);
        for (i = 0; i < 8; i = i + 1) begin
            wr(`PCS_IDX_PULSEMODE, {29'h011, i[2:0]});
            chk({31'h0, signOut[3]}, {31'h0, i < 3});
        end
        wr(`PCS_IDX_PULSEMODE, 32'h088);
        wr(`PCS_IDX_COMPUTATION_MODE_REG, 32'h1fa);
        rc(`PCS_IDX_SIGN, 32'h1a5, 1'b0);
        wr(`PCS_IDX_IRQSTAT, 32'h1ff);
        rc(`PCS_IDX_IRQSTAT, 32'h0, 1'b0);
        rc(`PCS_IDX_IRQMASK, 32'h0, 1'b0);
        @(posedge core_clk);
        tA <= ph(24'h64, 24'h32, -24'h0a);
        repeat (3) @(posedge core_clk);
        rc(`PCS_IDX_IRQSTAT, 32'h1, 1'b0);
        chk({31'h0, irq}, 32'h0);
        wr(`PCS_IDX_IRQMASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(`PCS_IDX_IRQSTAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rc(`PCS_IDX_IRQSTAT, 32'h0, 1'b0);
        tally_and_finish;
    end
endmodule // phase_cal_and_power_sign_regs_bench
bind pcs_regs pcs_regs_checker #(.PWR_W(PWR_W),
    .HAS_REACTIVE(HAS_REACTIVE)) pcsChk (
    .core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .totActPwr(totActPwr),
    .totReactPwr(totReactPwr), .fundActPwr(fundActPwr),
    .fundReactPwr(fundReactPwr), .phaseACompEff(phaseACompEff),
    .phaseBCompEff(phaseBCompEff), .phaseCCompEff(phaseCCompEff),
    .signOut(signOut));
